// File: loc_cfg.svh
// Constants for the logic output conditioner: offsets, fields, resets, timing
`ifndef LOC_CFG_SVH
`define LOC_CFG_SVH
`define LOC_CLK_HZ          100000000
`define LOC_TICK_MS         1
`define LOC_TICK_CYCLES     (`LOC_CLK_HZ / 1000 * `LOC_TICK_MS)
`define LOC_ON_DELAY_MAX    60000
`define LOC_HOLD_MAX        9999
`define LOC_OFS_CTRL        12'h000
`define LOC_OFS_STATUS      12'h004
`define LOC_OFS_CFG_BASE    12'h010
`define LOC_OFS_TIME_BASE   12'h020
`define LOC_CFG_ASSIGN_LSB  0
`define LOC_CFG_ASSIGN_W    4
`define LOC_CFG_NEG_BIT     8
`define LOC_TIME_ON_LSB     0
`define LOC_TIME_HOLD_LSB   16
`define LOC_RST_ASSIGN      4'h0
`define LOC_RST_TIME        16'h0000
`endif

// File: loc_pkg.sv
// Types for the logic output conditioner
package loc_pkg;
  typedef enum logic [3:0] {
    LOC_ASSIGN_NONE         = 4'h0,
    LOC_ASSIGN_NO_FAULT     = 4'h1,
    LOC_ASSIGN_BRAKE        = 4'h2,
    LOC_ASSIGN_LINE         = 4'h3,
    LOC_ASSIGN_DC_PRECHARGE = 4'h4,
    LOC_ASSIGN_RUNNING      = 4'h5,
    LOC_ASSIGN_AT_SPEED     = 4'h6,
    LOC_ASSIGN_USER         = 4'h7
  } loc_assign_t;

  function automatic logic loc_protected(input logic [3:0] a);
    return (a == LOC_ASSIGN_NO_FAULT) || (a == LOC_ASSIGN_BRAKE) ||
           (a == LOC_ASSIGN_LINE) || (a == LOC_ASSIGN_DC_PRECHARGE);
  endfunction : loc_protected
endpackage : loc_pkg

// File: loc_channel.sv
// One output channel: on-delay, holding time and polarity shaping
`timescale 1ns/1ps
`include "loc_cfg.svh"
module loc_channel
  import loc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        enable_i,
  input  wire logic        cond_i,
  input  wire logic        protect_i,
  input  wire logic        active_low_sense_i,
  input  wire logic [15:0] on_delay_i,
  input  wire logic [15:0] hold_time_i,
  output logic             state_o,
  output logic             pin_o
);
  logic [15:0] count;
  logic [15:0] on_eff;
  logic [15:0] hold_eff;
  logic        sense_low;

  assign on_eff    = protect_i ? 16'h0000 : on_delay_i;
  assign hold_eff  = protect_i ? 16'h0000 : hold_time_i;
  assign sense_low = protect_i ? 1'b0 : active_low_sense_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_i) begin
      state_o <= 1'b0;
      count   <= 16'h0000;
    end else if (cond_i == state_o) begin
      count <= 16'h0000;
    end else if (cond_i && count >= on_eff) begin
      state_o <= 1'b1;
      count   <= 16'h0000;
    end else if (!cond_i && count >= hold_eff) begin
      state_o <= 1'b0;
      count   <= 16'h0000;
    end else if (tick_i) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= enable_i & (state_o ^ sense_low);
    end
  end
endmodule : loc_channel

// File: loc_top.sv
// APB-controlled conditioner for logic outputs two to four
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "loc_cfg.svh"
module loc_top
  import loc_pkg::*;
#(
  parameter int NUM_OUT    = 3,
  parameter int TICK_CYCLES = `LOC_TICK_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  input  wire logic                card_fitted_i,
  input  wire logic [NUM_OUT-1:0]  cond_i,
  input  wire logic [NUM_OUT-1:0]  source_cond_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  output logic      [NUM_OUT-1:0]  out_pin_o
);
  if (NUM_OUT != 3 || TICK_CYCLES < 1) begin : g_bad_params
    $error("loc_top: unsupported parameters");
  end

  logic [3:0]         assign_sel [NUM_OUT];
  logic [NUM_OUT-1:0] active_low_sense;
  logic [15:0]        on_delay   [NUM_OUT];
  logic [15:0]        hold_time  [NUM_OUT];
  logic [NUM_OUT-1:0] state;
  logic [NUM_OUT-1:0] pin;
  logic [NUM_OUT-1:0] chan_en;
  logic [NUM_OUT-1:0] chan_cond;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic               card_fitted;
  logic               wr_en;
  logic               setup;

  // Millisecond tick
  always_ff @(posedge core_clk_i) begin
    if (rst_i || tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick        <= 1'b0;
      card_fitted <= 1'b0;
    end else begin
      tick        <= (tick_cnt == 32'(TICK_CYCLES - 1));
      card_fitted <= card_fitted_i;
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  assign setup = psel_i & penable_i & ~pready_o;
  assign wr_en = setup & pwrite_i;

  function automatic logic [1:0] chan_of(input logic [11:0] a, input logic [11:0] base);
    return 2'((a - base) >> 2);
  endfunction : chan_of

  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    return (a >= base) && (a < base + 12'h00C) && (a[1:0] == 2'b00);
  endfunction : in_bank

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      if (setup) begin
        if (paddr_i == `LOC_OFS_CTRL) begin
          prdata_o <= {31'h00000000, card_fitted};
        end else if (paddr_i == `LOC_OFS_STATUS) begin
          prdata_o <= {21'h000000, 1'(pin[2]), 1'(pin[1]), 1'(pin[0]), 5'h00, state};
        end else if (in_bank(paddr_i, `LOC_OFS_CFG_BASE)) begin
          prdata_o <= {23'h000000, active_low_sense[chan_of(paddr_i, `LOC_OFS_CFG_BASE)],
                       4'h0, assign_sel[chan_of(paddr_i, `LOC_OFS_CFG_BASE)]};
        end else if (in_bank(paddr_i, `LOC_OFS_TIME_BASE)) begin
          prdata_o <= {hold_time[chan_of(paddr_i, `LOC_OFS_TIME_BASE)],
                       on_delay[chan_of(paddr_i, `LOC_OFS_TIME_BASE)]};
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  // Per-output configuration and channels
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        assign_sel[i]       <= `LOC_RST_ASSIGN;
        active_low_sense[i] <= 1'b0;
      end else if (wr_en && in_bank(paddr_i, `LOC_OFS_CFG_BASE) &&
                   chan_of(paddr_i, `LOC_OFS_CFG_BASE) == 2'(i)) begin
        assign_sel[i] <= pwdata_i[`LOC_CFG_ASSIGN_LSB +: `LOC_CFG_ASSIGN_W];
        if (loc_protected(pwdata_i[`LOC_CFG_ASSIGN_LSB +: `LOC_CFG_ASSIGN_W])) begin
          active_low_sense[i] <= 1'b0;
        end else begin
          active_low_sense[i] <= pwdata_i[`LOC_CFG_NEG_BIT];
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        on_delay[i]  <= `LOC_RST_TIME;
        hold_time[i] <= `LOC_RST_TIME;
      end else if (loc_protected(assign_sel[i])) begin
        on_delay[i]  <= 16'h0000;
        hold_time[i] <= 16'h0000;
      end else if (wr_en && in_bank(paddr_i, `LOC_OFS_TIME_BASE) &&
                   chan_of(paddr_i, `LOC_OFS_TIME_BASE) == 2'(i)) begin
        on_delay[i] <= (pwdata_i[15:0] > 16'(`LOC_ON_DELAY_MAX)) ?
                       16'(`LOC_ON_DELAY_MAX) : pwdata_i[15:0];
        hold_time[i] <= (pwdata_i[31:16] > 16'(`LOC_HOLD_MAX)) ?
                        16'(`LOC_HOLD_MAX) : pwdata_i[31:16];
      end
    end

    // Outputs three and four need the extension card
    assign chan_en[i]   = (i == 0) ? 1'b1 : card_fitted;
    assign chan_cond[i] = (assign_sel[i] == LOC_ASSIGN_NONE) ? 1'b0 :
                          (assign_sel[i] == LOC_ASSIGN_USER) ? source_cond_i[i] : cond_i[i];

    loc_channel loc_channel_inst (
      .core_clk_i         (core_clk_i),
      .rst_i              (rst_i),
      .tick_i             (tick),
      .enable_i           (chan_en[i]),
      .cond_i             (chan_cond[i]),
      .protect_i          (loc_protected(assign_sel[i])),
      .active_low_sense_i (active_low_sense[i]),
      .on_delay_i         (on_delay[i]),
      .hold_time_i        (hold_time[i]),
      .state_o            (state[i]),
      .pin_o              (pin[i])
    );
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_pin_o <= '0;
    end else begin
      out_pin_o <= pin;
    end
  end
endmodule : loc_top

// File: loc_load.sv
// Relay load model hanging on the conditioned outputs
`timescale 1ns/1ps
module loc_load (
  input  wire logic       core_clk_i,
  input  wire logic [2:0] coil_i,
  output logic      [2:0] contact_o
);
  // Contacts follow the coils one cycle later
  always_ff @(posedge core_clk_i) begin
    contact_o <= coil_i;
  end
endmodule : loc_load

// File: loc_checker.sv
// Port assertions for the logic output conditioner
`timescale 1ns/1ps
module loc_checker #(
  parameter int NUM_OUT = 3
) (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic [11:0]        paddr_i,
  input wire logic               card_fitted_i,
  input wire logic [31:0]        prdata_o,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire logic [NUM_OUT-1:0] out_pin_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    psel_i && penable_i && !pready_o;
  endsequence
  a_ready_after: assert property (s_req |=> pready_o) else $error("no ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("stray ready");
  a_idle_quiet: assert property (!psel_i |=> !pready_o) else $error("idle ready");
  a_err_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad err");
  a_err_unmapped: assert property ((s_req and paddr_i == 12'hFFC) |=> pslverr_o)
    else $error("no err");
  a_reset_low: assert property ($fell(rst_i) |-> out_pin_o == '0) else $error("pin high");
  a_card_gate: assert property (!card_fitted_i [*6] |-> out_pin_o[2:1] == 2'h0)
    else $error("card gate");
endmodule : loc_checker
bind loc_top loc_checker #(.NUM_OUT(NUM_OUT)) loc_checker_inst (.core_clk_i, .rst_i, .psel_i,
  .penable_i, .paddr_i, .card_fitted_i, .prdata_o, .pready_o, .pslverr_o, .out_pin_o);

// File: loc_top_bench.sv
// Self-checking bench for the logic output conditioner
`timescale 1ns/1ps
module loc_top_bench;
  logic        core_clk_i, rst_i, psel_i, penable_i, pwrite_i, card_fitted_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, src;
  logic [2:0]  cond_i, source_cond_i, out_pin_o, contact;
  logic [65:0] q[$];
  logic [65:0] n;
  int          mismatches = 0, checks = 0, seed = 32'h3120DE96;
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  loc_top #(.NUM_OUT(3), .TICK_CYCLES(10)) loc_top_inst (.core_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .card_fitted_i, .cond_i, .source_cond_i,
    .prdata_o, .pready_o, .pslverr_o, .out_pin_o);
  loc_load loc_load_inst (.core_clk_i, .coil_i(out_pin_o), .contact_o(contact));
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [65:0] e);
    int k;
    q.push_back(e);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin @(posedge core_clk_i); k++; end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin mismatches++; test_done(); end
    psel_i <= 1'b0; penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 66'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic er = 1'b0);
    xfer(1'b0, a, 32'h0, {1'b1, er, m, e});
  endtask : rd
  task automatic ms(input int c);
    repeat (c * 10) @(posedge core_clk_i);
  endtask : ms
  // Relay contacts seen by the load model
  task automatic pin_chk(input logic [2:0] e);
    checks++;
    if (contact !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, contact);
    end
  endtask : pin_chk
  // Results are matched against the oldest note
  always @(posedge core_clk_i) begin
    if (pready_o === 1'b1) begin
      n = (q.size() > 0) ? q.pop_front() : {2'b11, 64'h0};
      checks++;
      if (pslverr_o !== n[64] || (n[65] && ((prdata_o ^ n[31:0]) & n[63:32]) !== 32'h0)) begin
        mismatches++;
        $display("BAD t=%0t exp=%h got=%h", $time, n[31:0], prdata_o);
      end
    end
  end
  initial begin
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h0;
    pwdata_i = 32'h0; card_fitted_i = 1'b1; cond_i = 3'h0; source_cond_i = 3'h0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(12'h010, 32'h0);
    rd(12'h020, 32'h0);
    rd(12'h000, 32'h1);
    rd(12'hFFC, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(12'h020, 32'hFFFFFFFF);
    rd(12'h020, 32'h270FEA60);
    for (int a = 0; a < 8; a++) begin
      wr(12'h010, 32'h100 | a);
      wr(12'h020, 32'h00050005);
      rd(12'h010, (a >= 1 && a <= 4) ? a : 32'h100 | a);
      rd(12'h020, (a >= 1 && a <= 4) ? 32'h0 : 32'h00050005);
    end
    wr(12'h020, 32'h0);
    for (int i = 0; i < 2; i++) begin
      src = $random(seed);
      source_cond_i <= src[2:0];
      wr(12'h010, {23'h0, i[0], 8'h07});
      repeat (6) @(posedge core_clk_i);
      rd(12'h004, {23'h0, src[0] ^ i[0], 7'h0, src[0]}, 32'h101);
      pin_chk({2'b00, src[0] ^ i[0]});
    end
    wr(12'h010, 32'h5);
    wr(12'h020, 32'h5);
    ms(1);
    cond_i <= 3'h1;
    ms(3);
    rd(12'h004, 32'h0, 32'h1);
    cond_i <= 3'h0;
    @(posedge core_clk_i);
    cond_i <= 3'h1;
    ms(3);
    rd(12'h004, 32'h0, 32'h1);
    ms(4);
    rd(12'h004, 32'h1, 32'h1);
    pin_chk(3'h1);
    wr(12'h020, 32'h00050000);
    cond_i <= 3'h0;
    ms(3);
    rd(12'h004, 32'h1, 32'h1);
    ms(4);
    rd(12'h004, 32'h0, 32'h1);
    pin_chk(3'h0);
    card_fitted_i <= 1'b0;
    wr(12'h014, 32'h5);
    cond_i <= 3'h2;
    repeat (8) @(posedge core_clk_i);
    rd(12'h004, 32'h0, 32'h200);
    pin_chk(3'h0);
    card_fitted_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rd(12'h004, 32'h200, 32'h200);
    pin_chk(3'h2);
    test_done();
  end
endmodule : loc_top_bench
